// ### pfs_regs.vh
// Register map, field positions and codes for the pin function select block
`ifndef PFS_REGS_VH
`define PFS_REGS_VH

// ----------------------------------------
// Bus and addresses
// ----------------------------------------
`define PFS_ADDR_W 12
`define PFS_DATA_W 32
`define PFS_REG_W 16
`define PFS_OFF_PEMODE 12'h000
`define PFS_OFF_ACKCTL 12'h004
`define PFS_OFF_PDCTL 12'h008
`define PFS_OFF_PECTL 12'h00C
`define PFS_IDX_PINLVL 32'hFFFFD382
`define PFS_IDX_SHIFT 2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PFS_E7_MSB 14
`define PFS_E7_LSB 12
`define PFS_E6_MSB 10
`define PFS_E6_LSB 8
`define PFS_ACKD_MSB 3
`define PFS_ACKD_LSB 2
`define PFS_ACKE_MSB 1
`define PFS_ACKE_LSB 0
`define PFS_PD30_MSB 9
`define PFS_PD30_LSB 8
`define PFS_PE15_MSB 14
`define PFS_PE15_LSB 12

// ----------------------------------------
// Writable bit masks, reset values and input port masks
// ----------------------------------------
`define PFS_PEMODE_MASK 16'h7700
`define PFS_ACKCTL_MASK 16'h000F
`define PFS_PDCTL_MASK 16'h0300
`define PFS_PECTL_MASK 16'h7000
`define PFS_REG_RESET 16'h0000
`define PFS_PINS_SMALL_MASK 16'h00FF
`define PFS_PINS_LARGE_MASK 16'hFFFF
`define PFS_ADC_ONES 16'hFFFF

// ----------------------------------------
// Mode, acknowledge selector and ack routing codes
// ----------------------------------------
`define PFS_MODE_PORT 3'h0
`define PFS_MODE_TIMER 3'h1
`define PFS_MODE_SERIAL 3'h2
`define PFS_MODE_BUSSTATE 3'h3
`define PFS_MODE_SYNCDATA 3'h5
`define PFS_MODE_BRKTRIG 3'h7
`define PFS_MODE_CHIPSEL 3'h5
`define PFS_ACK_ACCEPT 2'h0
`define PFS_ACK_REFRESH 2'h1
`define PFS_ACK_EITHER 2'h2
`define PFS_ACK_HIGH 2'h3
`define PFS_PD30_ACKOUT 2'h2
`define PFS_PE15_ACKOUT 3'h3

`endif

// ### pfs_sync2.v
// Two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module pfs_sync2 #(
  parameter WIDTH = 1
) (
  input wire clk_sys,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg stage1Q;
      reg stage2Q;
      always @(posedge clk_sys) begin
        stage1Q <= asyncIn[i];
        stage2Q <= stage1Q;
      end
      assign syncOut[i] = stage2Q;
    end
  endgenerate
endmodule // pfs_sync2

// ### pfs_ack_select.v
// Acknowledge output level selector
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_ack_select (
  input wire [1:0] ackSel,
  input wire intAccept,
  input wire refreshReq,
  input wire refreshActive,
  output reg ackLevel
);
  always @* begin
    case (ackSel)
      `PFS_ACK_ACCEPT: ackLevel = intAccept;
      `PFS_ACK_REFRESH: ackLevel = refreshReq;
      `PFS_ACK_EITHER: ackLevel = refreshActive ? refreshReq : intAccept;
      `PFS_ACK_HIGH: ackLevel = 1'b1;
      default: ackLevel = 1'b1;
    endcase
  end
endmodule // pfs_ack_select

// ### pfs_pin_function_select.v
// Pin function select, acknowledge output control and input port top
//
// Behaviour
// - Pin E7 follows its 3-bit mode; unlisted codes are prohibited.
// - Pin E6 follows its 3-bit mode; unlisted codes are prohibited.
// - Active debug trace forces pin E6 to trace data output.
// - Reserved bits read zero; software writes zero there.
// - 16-bit ack control register only matters where ack output is routed.
// - Ack control bits 3:2 serve port D pin when its field is 10.
// - Selector: 00 accept, 01 refresh, 10 either by state, 11 high.
// - Ack control bits 1:0 serve port E pin when its field is 011.
// - Input port register is read-only; writes are dropped.
// - Input port read returns live pin levels.
// - Pins under analog sampling read as one.
// - Input port is 8 bits on small package, 16 on large.
`timescale 1ns/1ns
`include "pfs_regs.vh"
module pfs_pin_function_select (
  input wire clk_sys,
  input wire srst,
  input wire [`PFS_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PFS_DATA_W-1:0] pwdata,
  output wire [`PFS_DATA_W-1:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire pinE7In,
  output wire pinE7Out,
  output wire pinE7Oe,
  input wire pinE6In,
  output wire pinE6Out,
  output wire pinE6Oe,
  input wire [`PFS_REG_W-1:0] inputPins,
  input wire [`PFS_REG_W-1:0] adcSampling,
  input wire largePackage,
  input wire traceActive,
  input wire traceData0,
  input wire gpioE7Out,
  input wire gpioE7Oe,
  output wire gpioE7In,
  input wire timerCh2IoBOut,
  input wire timerCh2IoBOe,
  output wire timerCh2IoBIn,
  output wire serial2ReceiveIn,
  input wire busStateOut,
  input wire syncSerialDataOut,
  input wire syncSerialDataOe,
  output wire syncSerialDataIn,
  input wire breakTriggerOut,
  input wire gpioE6Out,
  input wire gpioE6Oe,
  output wire gpioE6In,
  input wire timerCh2IoAOut,
  input wire timerCh2IoAOe,
  output wire timerCh2IoAIn,
  input wire serial3ClockOut,
  input wire serial3ClockOe,
  output wire serial3ClockIn,
  input wire chipSelectSeven,
  input wire intAccept,
  input wire refreshReq,
  input wire refreshActive,
  output wire portdAckOut,
  output wire portdAckOe,
  output wire porteAckOut,
  output wire porteAckOe
);

  // ----------------------------------------
  // Address constants
  // ----------------------------------------
  localparam [31:0] PIN_LVL_BYTE = `PFS_IDX_PINLVL << `PFS_IDX_SHIFT;
  localparam [`PFS_ADDR_W-1:0] PIN_LVL_ADDR = PIN_LVL_BYTE[`PFS_ADDR_W-1:0];

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  wire [`PFS_REG_W+1:0] rawPins;
  wire [`PFS_REG_W+1:0] syncPins;
  wire [`PFS_REG_W-1:0] portPinsS;
  wire e7PinS;
  wire e6PinS;
  wire setupPhase;
  wire wrDone;
  wire rdAccess;
  wire addrHit;
  wire [2:0] e7Mode;
  wire [2:0] e6Mode;
  wire [1:0] ackSelD;
  wire [1:0] ackSelE;
  wire pdAckRouted;
  wire peAckRouted;
  wire ackLevelD;
  wire ackLevelE;
  reg [`PFS_REG_W-1:0] peModeQ;
  reg [`PFS_REG_W-1:0] ackCtlQ;
  reg [`PFS_REG_W-1:0] pdCtlQ;
  reg [`PFS_REG_W-1:0] peCtlQ;
  reg largePkgQ;
  reg pkgTakenQ;
  reg preadyQ;
  reg pslverrQ;
  reg [`PFS_DATA_W-1:0] prdataQ;
  reg [`PFS_REG_W-1:0] rdMux;
  reg rdHit;
  reg [`PFS_REG_W-1:0] pinLevels;
  reg e7Out_d;
  reg e7Oe_d;
  reg e6Out_d;
  reg e6Oe_d;
  reg gpio7In_d;
  reg timBIn_d;
  reg ser2In_d;
  reg ssdIn_d;
  reg gpio6In_d;
  reg timAIn_d;
  reg ser3In_d;
  reg e7Out_q;
  reg e7Oe_q;
  reg e6Out_q;
  reg e6Oe_q;
  reg gpio7In_q;
  reg timBIn_q;
  reg ser2In_q;
  reg ssdIn_q;
  reg gpio6In_q;
  reg timAIn_q;
  reg ser3In_q;
  reg pdAckOut_q;
  reg pdAckOe_q;
  reg peAckOut_q;
  reg peAckOe_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign rawPins = {pinE7In, pinE6In, inputPins};

  pfs_sync2 #(
    .WIDTH(`PFS_REG_W + 2)
  ) uPinSync (
    .clk_sys(clk_sys),
    .asyncIn(rawPins),
    .syncOut(syncPins)
  );

  assign portPinsS = syncPins[`PFS_REG_W-1:0];
  assign e6PinS = syncPins[`PFS_REG_W];
  assign e7PinS = syncPins[`PFS_REG_W+1];

  // ----------------------------------------
  // Package strap
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      pkgTakenQ <= 1'b0;
      largePkgQ <= 1'b0;
    end else if (!pkgTakenQ) begin
      pkgTakenQ <= 1'b1;
      largePkgQ <= largePackage;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setupPhase = psel & penable & ~preadyQ;
  assign wrDone = psel & penable & preadyQ & pwrite;
  assign rdAccess = setupPhase & ~pwrite;
  assign addrHit = rdHit;

  always @* begin
    rdMux = `PFS_REG_RESET;
    rdHit = 1'b1;
    case (paddr)
      `PFS_OFF_PEMODE: rdMux = peModeQ;
      `PFS_OFF_ACKCTL: rdMux = ackCtlQ;
      `PFS_OFF_PDCTL: rdMux = pdCtlQ;
      `PFS_OFF_PECTL: rdMux = peCtlQ;
      PIN_LVL_ADDR: rdMux = pinLevels;
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
      prdataQ <= {`PFS_DATA_W{1'b0}};
    end else if (setupPhase) begin
      preadyQ <= 1'b1;
      pslverrQ <= ~addrHit;
      if (rdAccess) begin
        prdataQ <= {{(`PFS_DATA_W-`PFS_REG_W){1'b0}}, rdMux};
      end else begin
        prdataQ <= {`PFS_DATA_W{1'b0}};
      end
    end else begin
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
    end
  end

  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      peModeQ <= `PFS_REG_RESET;
      ackCtlQ <= `PFS_REG_RESET;
      pdCtlQ <= `PFS_REG_RESET;
      peCtlQ <= `PFS_REG_RESET;
    end else if (wrDone) begin
      case (paddr)
        `PFS_OFF_PEMODE: peModeQ <= pwdata[`PFS_REG_W-1:0] & `PFS_PEMODE_MASK;
        `PFS_OFF_ACKCTL: ackCtlQ <= pwdata[`PFS_REG_W-1:0] & `PFS_ACKCTL_MASK;
        `PFS_OFF_PDCTL: pdCtlQ <= pwdata[`PFS_REG_W-1:0] & `PFS_PDCTL_MASK;
        `PFS_OFF_PECTL: peCtlQ <= pwdata[`PFS_REG_W-1:0] & `PFS_PECTL_MASK;
        default: peModeQ <= peModeQ;
      endcase
    end
  end

  // ----------------------------------------
  // Input port levels
  // ----------------------------------------
  always @* begin
    pinLevels = portPinsS | (adcSampling & `PFS_ADC_ONES);
    if (largePkgQ) begin
      pinLevels = pinLevels & `PFS_PINS_LARGE_MASK;
    end else begin
      pinLevels = pinLevels & `PFS_PINS_SMALL_MASK;
    end
  end

  // ----------------------------------------
  // Shared pin E7 routing
  // ----------------------------------------
  assign e7Mode = peModeQ[`PFS_E7_MSB:`PFS_E7_LSB];

  always @* begin
    e7Out_d = 1'b0;
    e7Oe_d = 1'b0;
    gpio7In_d = 1'b1;
    timBIn_d = 1'b1;
    ser2In_d = 1'b1;
    ssdIn_d = 1'b1;
    case (e7Mode)
      `PFS_MODE_PORT: begin
        e7Out_d = gpioE7Out;
        e7Oe_d = gpioE7Oe;
        gpio7In_d = e7PinS;
      end
      `PFS_MODE_TIMER: begin
        e7Out_d = timerCh2IoBOut;
        e7Oe_d = timerCh2IoBOe;
        timBIn_d = e7PinS;
      end
      `PFS_MODE_SERIAL: begin
        ser2In_d = e7PinS;
      end
      `PFS_MODE_BUSSTATE: begin
        e7Out_d = busStateOut;
        e7Oe_d = 1'b1;
      end
      `PFS_MODE_SYNCDATA: begin
        e7Out_d = syncSerialDataOut;
        e7Oe_d = syncSerialDataOe;
        ssdIn_d = e7PinS;
      end
      `PFS_MODE_BRKTRIG: begin
        e7Out_d = breakTriggerOut;
        e7Oe_d = 1'b1;
      end
      default: e7Oe_d = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Shared pin E6 routing
  // ----------------------------------------
  assign e6Mode = peModeQ[`PFS_E6_MSB:`PFS_E6_LSB];

  always @* begin
    e6Out_d = 1'b0;
    e6Oe_d = 1'b0;
    gpio6In_d = 1'b1;
    timAIn_d = 1'b1;
    ser3In_d = 1'b1;
    if (traceActive) begin
      e6Out_d = traceData0;
      e6Oe_d = 1'b1;
    end else begin
      case (e6Mode)
        `PFS_MODE_PORT: begin
          e6Out_d = gpioE6Out;
          e6Oe_d = gpioE6Oe;
          gpio6In_d = e6PinS;
        end
        `PFS_MODE_TIMER: begin
          e6Out_d = timerCh2IoAOut;
          e6Oe_d = timerCh2IoAOe;
          timAIn_d = e6PinS;
        end
        `PFS_MODE_SERIAL: begin
          e6Out_d = serial3ClockOut;
          e6Oe_d = serial3ClockOe;
          ser3In_d = e6PinS;
        end
        `PFS_MODE_CHIPSEL: begin
          e6Out_d = chipSelectSeven;
          e6Oe_d = 1'b1;
        end
        default: e6Oe_d = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Acknowledge output selection
  // ----------------------------------------
  assign ackSelD = ackCtlQ[`PFS_ACKD_MSB:`PFS_ACKD_LSB];
  assign ackSelE = ackCtlQ[`PFS_ACKE_MSB:`PFS_ACKE_LSB];
  assign pdAckRouted = pdCtlQ[`PFS_PD30_MSB:`PFS_PD30_LSB] == `PFS_PD30_ACKOUT;
  assign peAckRouted = peCtlQ[`PFS_PE15_MSB:`PFS_PE15_LSB] == `PFS_PE15_ACKOUT;

  pfs_ack_select uAckD (
    .ackSel(ackSelD),
    .intAccept(intAccept),
    .refreshReq(refreshReq),
    .refreshActive(refreshActive),
    .ackLevel(ackLevelD)
  );

  pfs_ack_select uAckE (
    .ackSel(ackSelE),
    .intAccept(intAccept),
    .refreshReq(refreshReq),
    .refreshActive(refreshActive),
    .ackLevel(ackLevelE)
  );

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      e7Out_q <= 1'b0;
      e7Oe_q <= 1'b0;
      e6Out_q <= 1'b0;
      e6Oe_q <= 1'b0;
      gpio7In_q <= 1'b1;
      timBIn_q <= 1'b1;
      ser2In_q <= 1'b1;
      ssdIn_q <= 1'b1;
      gpio6In_q <= 1'b1;
      timAIn_q <= 1'b1;
      ser3In_q <= 1'b1;
      pdAckOut_q <= 1'b0;
      pdAckOe_q <= 1'b0;
      peAckOut_q <= 1'b0;
      peAckOe_q <= 1'b0;
    end else begin
      e7Out_q <= e7Out_d;
      e7Oe_q <= e7Oe_d;
      e6Out_q <= e6Out_d;
      e6Oe_q <= e6Oe_d;
      gpio7In_q <= gpio7In_d;
      timBIn_q <= timBIn_d;
      ser2In_q <= ser2In_d;
      ssdIn_q <= ssdIn_d;
      gpio6In_q <= gpio6In_d;
      timAIn_q <= timAIn_d;
      ser3In_q <= ser3In_d;
      pdAckOut_q <= pdAckRouted & ackLevelD;
      pdAckOe_q <= pdAckRouted;
      peAckOut_q <= peAckRouted & ackLevelE;
      peAckOe_q <= peAckRouted;
    end
  end

  assign pinE7Out = e7Out_q;
  assign pinE7Oe = e7Oe_q;
  assign pinE6Out = e6Out_q;
  assign pinE6Oe = e6Oe_q;
  assign gpioE7In = gpio7In_q;
  assign timerCh2IoBIn = timBIn_q;
  assign serial2ReceiveIn = ser2In_q;
  assign syncSerialDataIn = ssdIn_q;
  assign gpioE6In = gpio6In_q;
  assign timerCh2IoAIn = timAIn_q;
  assign serial3ClockIn = ser3In_q;
  assign portdAckOut = pdAckOut_q;
  assign portdAckOe = pdAckOe_q;
  assign porteAckOut = peAckOut_q;
  assign porteAckOe = peAckOe_q;

endmodule // pfs_pin_function_select

// ### pfs_pin_function_select_asserts.sv
// Port-level checks on the pin function select block
`timescale 1ns/1ns
module pfs_pin_function_select_asserts (
  input wire clk_sys,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire traceActive,
  input wire traceData0,
  input wire pinE6Oe,
  input wire pinE6Out,
  input wire pinE7In,
  input wire pinE6In,
  input wire serial2ReceiveIn,
  input wire serial3ClockIn,
  input wire portdAckOe,
  input wire portdAckOut,
  input wire porteAckOe
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  ack_idle_a: assert property (!portdAckOe |-> !portdAckOut)
    else $error("ack driven unrouted");
  trace_force_a: assert property (!$past(srst) && $past(traceActive)
    |-> pinE6Oe && pinE6Out == $past(traceData0))
    else $error("trace not forced");
  rx_path_a: assert property (!serial2ReceiveIn |-> !$past(pinE7In, 3))
    else $error("receive path wrong");
  sck_path_a: assert property (!serial3ClockIn |-> !$past(pinE6In, 3))
    else $error("clock path wrong");
  ack_change_a: assert property ($changed(porteAckOe) || $changed(portdAckOe)
    |-> $past(pwrite && pready, 2))
    else $error("routing changed off write");
endmodule // pfs_pin_function_select_asserts

// ### pfs_pin_partner.sv
// Board side model of the two shared port E pins
`timescale 1ns/1ns
module pfs_pin_partner (
  input wire pinE7Out,
  input wire pinE7Oe,
  input wire pinE6Out,
  input wire pinE6Oe,
  input wire ext7,
  input wire ext6,
  output wire pinE7In,
  output wire pinE6In
);
  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  assign pinE7In = pinE7Oe ? pinE7Out : ext7;
  assign pinE6In = pinE6Oe ? pinE6Out : ext6;
endmodule // pfs_pin_partner

// ### testbench.sv
// Self-checking bench for the pin function select block
`timescale 1ns/1ns
`include "pfs_regs.vh"
module testbench;
  // ----------------------------------------
  // Signals and model
  // ----------------------------------------
  localparam logic [15:0] MASKS [4] = '{`PFS_PEMODE_MASK, `PFS_ACKCTL_MASK,
    `PFS_PDCTL_MASK, `PFS_PECTL_MASK};
  localparam logic [11:0] PIN_ADDR = 12'(`PFS_IDX_PINLVL * 4);
  logic clk_sys = 0;
  logic srst = 1;
  logic [11:0] paddr = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] pwdata = 0;
  logic [15:0] inputPins = 0;
  logic [15:0] adcSampling = 0;
  logic largePackage = 0;
  logic traceActive = 0;
  logic [20:0] per = 0;
  logic [31:0] seed = 32'hF344;
  logic [31:0] rd;
  logic er;
  logic [15:0] mregs [4];
  wire [31:0] prdata;
  wire pready, pslverr, pinE7In, pinE7Out, pinE7Oe, pinE6In, pinE6Out, pinE6Oe;
  wire dAckOut, dAckOe, eAckOut, eAckOe;
  wire [3:0] in7;
  wire [3:0] in6;
  logic [15:0] pexp;
  logic [1:0] ex;
  int errTotal = 0;
  int testsRun = 0;
  assign in6[0] = 1'b1;
  always #4 clk_sys = ~clk_sys;

  pfs_pin_function_select DUT (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinE7In(pinE7In), .pinE7Out(pinE7Out), .pinE7Oe(pinE7Oe),
    .pinE6In(pinE6In), .pinE6Out(pinE6Out), .pinE6Oe(pinE6Oe), .inputPins(inputPins),
    .adcSampling(adcSampling), .largePackage(largePackage), .traceActive(traceActive),
    .traceData0(per[18]), .gpioE7Out(per[0]), .gpioE7Oe(per[1]), .gpioE7In(in7[3]),
    .timerCh2IoBOut(per[2]), .timerCh2IoBOe(per[3]), .timerCh2IoBIn(in7[2]),
    .serial2ReceiveIn(in7[1]), .busStateOut(per[4]), .syncSerialDataOut(per[5]),
    .syncSerialDataOe(per[6]), .syncSerialDataIn(in7[0]), .breakTriggerOut(per[7]),
    .gpioE6Out(per[8]), .gpioE6Oe(per[9]), .gpioE6In(in6[3]), .timerCh2IoAOut(per[10]),
    .timerCh2IoAOe(per[11]), .timerCh2IoAIn(in6[2]), .serial3ClockOut(per[12]),
    .serial3ClockOe(per[13]), .serial3ClockIn(in6[1]), .chipSelectSeven(per[14]),
    .intAccept(per[15]), .refreshReq(per[16]), .refreshActive(per[17]),
    .portdAckOut(dAckOut), .portdAckOe(dAckOe), .porteAckOut(eAckOut), .porteAckOe(eAckOe));
  pfs_pin_partner PINS (.pinE7Out(pinE7Out), .pinE7Oe(pinE7Oe), .pinE6Out(pinE6Out),
    .pinE6Oe(pinE6Oe), .ext7(per[19]), .ext6(per[20]), .pinE7In(pinE7In), .pinE6In(pinE6In));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [1:0] po(input logic oe, input logic o);
    return {oe, oe & o};
  endfunction
  function automatic logic [1:0] e7x(input int m);
    case (m)
      0: return po(per[1], per[0]);
      1: return po(per[3], per[2]);
      3: return po(1, per[4]);
      5: return po(per[6], per[5]);
      7: return po(1, per[7]);
      default: return 0;
    endcase
  endfunction
  function automatic logic [1:0] e6x(input int m);
    case (m)
      0: return po(per[9], per[8]);
      1: return po(per[11], per[10]);
      2: return po(per[13], per[12]);
      5: return po(1, per[14]);
      default: return 0;
    endcase
  endfunction
  function automatic logic [3:0] ix(input int m, input logic [1:0] p, input logic x,
    input logic f);
    logic l;
    logic [3:0] e;
    l = p[1] ? p[0] : x;
    e = 4'hF;
    if (m < 3) e[3 - m] = l;
    if (m == 5 && f) e[0] = l;
    return e;
  endfunction
  function automatic logic ak(input int s);
    case (s)
      0: return per[15];
      1: return per[16];
      2: return per[17] ? per[16] : per[15];
      default: return 1;
    endcase
  endfunction
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errTotal++;
      tallyAndFinish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic reg_wr(input int i, input logic [15:0] d);
    apb(12'(i * 4), 1, {16'h0000, d});
    mregs[i] = d & MASKS[i];
    chk("write err", 32'(er), 0);
  endtask
  task automatic rst(input logic lp);
    @(posedge clk_sys);
    srst <= 1;
    largePackage <= lp;
    repeat (3) @(posedge clk_sys);
    srst <= 0;
    foreach (mregs[i]) mregs[i] = 0;
  endtask
  task automatic settle();
    @(posedge clk_sys);
    per <= 21'(rnd());
    repeat (6) @(posedge clk_sys);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst(0);
    for (int i = 0; i < 4; i++) begin
      apb(12'(i * 4), 0, 0);
      chk("reset value", rd, 0);
      reg_wr(i, 16'(rnd()) & MASKS[i]);
      apb(12'(i * 4), 0, 0);
      chk("readback", rd, {16'h0000, mregs[i]});
    end
    apb(12'h010, 1, rnd());
    chk("unmapped err", 32'(er), 1);
    apb(12'h010, 0, 0);
    chk("unmapped data", rd, 0);
    $display("test registers done");
    for (int p = 0; p < 2; p++) begin
      rst(p);
      for (int k = 0; k < 4; k++) begin
        inputPins <= 16'(rnd());
        adcSampling <= 16'(rnd() & rnd());
        repeat (3) @(posedge clk_sys);
        apb(PIN_ADDR, 1, rnd());
        chk("drop err", 32'(er), 0);
        apb(PIN_ADDR, 0, 0);
        pexp = (inputPins | adcSampling) & (p ? 16'hFFFF : 16'h00FF);
        chk("pin levels", rd, 32'(pexp));
      end
    end
    for (int i = 0; i < 4; i++) begin
      apb(12'(i * 4), 0, 0);
      chk("drop keeps", rd, {16'h0000, mregs[i]});
    end
    $display("test input port done");
    for (int m = 0; m < 8; m++) begin
      for (int t = 0; t < 2; t++) begin
        reg_wr(0, 16'((m << 12) | (m << 8)));
        traceActive <= t[0];
        settle();
        chk("e7 pin", 32'({pinE7Oe, pinE7Oe & pinE7Out}), 32'(e7x(m)));
        chk("e7 inputs", 32'(in7), 32'(ix(m, e7x(m), per[19], 1)));
        ex = t ? {1'b1, per[18]} : e6x(m);
        chk("e6 pin", 32'({pinE6Oe, pinE6Oe & pinE6Out}), 32'(ex));
        if (t == 0) chk("e6 inputs", 32'(in6), 32'(ix(m, e6x(m), per[20], 0)));
      end
    end
    traceActive <= 0;
    $display("test pin modes done");
    for (int r = 0; r < 2; r++) begin
      for (int s = 0; s < 4; s++) begin
        reg_wr(2, r ? 16'h0200 : 16'h0300);
        reg_wr(3, r ? 16'h3000 : 16'h7000);
        reg_wr(1, 16'((s << 2) | (3 - s)));
        settle();
        chk("portd ack", 32'({dAckOe, dAckOut}), r ? 32'(po(1, ak(s))) : 0);
        chk("porte ack", 32'({eAckOe, eAckOut}), r ? 32'(po(1, ak(3 - s))) : 0);
      end
    end
    $display("test ack output done");
    tallyAndFinish();
  end
endmodule // testbench

bind pfs_pin_function_select pfs_pin_function_select_asserts CHK (.clk_sys(clk_sys),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .traceActive(traceActive), .traceData0(traceData0),
  .pinE6Oe(pinE6Oe), .pinE6Out(pinE6Out), .pinE7In(pinE7In), .pinE6In(pinE6In),
  .serial2ReceiveIn(serial2ReceiveIn), .serial3ClockIn(serial3ClockIn),
  .portdAckOe(portdAckOe), .portdAckOut(portdAckOut), .porteAckOe(porteAckOe));
